//--- pkg/if_switch_pkg.sv
// shared constants and types of the switch matrix control
package if_switch_pkg;
  // ===========================================================
  // clock and timing
  localparam int unsigned CLOCK_MHZ    = 125;
  localparam int unsigned BIT_THRESH_US = 750;   // tone shorter than this is a one
  localparam int unsigned GAP_US        = 6000;  // silence that closes a frame
  localparam int unsigned TX_BIT_US     = 1500;
  localparam int unsigned TX_ONE_US     = 500;
  localparam int unsigned TX_ZERO_US    = 1000;
  localparam int unsigned BIT_THRESH_CYC = BIT_THRESH_US * CLOCK_MHZ;
  localparam int unsigned GAP_CYC        = GAP_US * CLOCK_MHZ;
  localparam int unsigned TX_BIT_CYC     = TX_BIT_US * CLOCK_MHZ;
  localparam int unsigned TX_ONE_CYC     = TX_ONE_US * CLOCK_MHZ;
  localparam int unsigned TX_ZERO_CYC    = TX_ZERO_US * CLOCK_MHZ;
  // ===========================================================
  // static level codes
  localparam logic [1:0] MODE_LNB    = 2'h0;
  localparam logic [1:0] MODE_SLAVE  = 2'h1;
  localparam logic [1:0] MODE_MASTER = 2'h2;
  localparam logic [1:0] MODE_SINGLE = 2'h3;
  localparam logic [1:0] GAIN_0DB    = 2'h0;
  localparam logic [1:0] GAIN_6DB    = 2'h1;
  localparam logic [1:0] GAIN_12DB   = 2'h2;
  // ===========================================================
  // bus frame bytes
  localparam logic [4:0] FRAMING_TOP = 5'h1c;  // framing bytes e0..e7
  localparam int unsigned FRAMING_REPLY_BIT = 1;  // e2/e3/e6/e7 ask for a reply
  localparam logic [7:0] REPLY_BYTE  = 8'he4;
  localparam logic [7:0] ADDR_ANY    = 8'h00;
  localparam logic [7:0] ADDR_FAMILY = 8'h10;
  localparam logic [7:0] ADDR_LNB    = 8'h11;
  localparam logic [7:0] ADDR_SWITCH = 8'h14;
  localparam logic [4:0] CMD_SWITCH_TOP = 5'h04;  // commands 20..27
  localparam logic [7:0] CMD_RESET   = 8'h00;
  localparam logic [7:0] CMD_SLEEP   = 8'h30;
  localparam logic [7:0] CMD_AWAKE   = 8'h31;
  localparam logic [7:0] CMD_WRITE_N0 = 8'h38;
  // ===========================================================
  // register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SELECT = 8'h08;
  localparam logic [7:0] REG_SWITCH = 8'h0c;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] SEL_RESET  = 4'h0;   // first primary input
  localparam logic [3:0] SEL_CHAINED = 4'h8;  // ninth source
  // ===========================================================
  // types
  typedef struct packed {
    logic option;
    logic pos;
    logic pol;
    logic band;
  } switch_state_t;
  typedef struct packed {
    logic [7:0] framing;
    logic [7:0] addr;
    logic [7:0] cmd;
    logic [7:0] data;
  } frame_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_TONE = 3'h2,
    TX_GAP  = 3'h4
  } tx_state_t;
endpackage

//--- rtl/envelope_slicer.sv
// turns a command envelope into bytes and an end-of-frame pulse
`timescale 1ns/1ps
module envelope_slicer #(
  parameter int unsigned CW         = 20,
  parameter int unsigned THRESH_CYC = 93750,
  parameter int unsigned GAP_CYC    = 750000
) (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       env,
  output logic            byte_valid,
  output logic [7:0]      byte_data,
  output logic            parity_ok,
  output logic            frame_end
);
  generate
    if (GAP_CYC >= (64'd1 << CW) || THRESH_CYC >= GAP_CYC) begin : g_bad
      $error("envelope_slicer: counter too narrow or thresholds misordered");
    end
  endgenerate

  logic          env_reg;
  logic [CW-1:0] cnt_reg;
  logic [8:0]    shift_reg;
  logic [3:0]    nbits_reg;
  logic          active_reg;
  wire           fall     = env_reg & ~env;
  wire           rise     = ~env_reg & env;
  wire           bit_val  = (cnt_reg < CW'(THRESH_CYC));  // short tone is a one
  wire [8:0]     shifted  = {shift_reg[7:0], bit_val};
  wire           gap_hit  = ~env & active_reg & (cnt_reg == CW'(GAP_CYC));

  // tone and silence are timed by one counter, restarted at each edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      env_reg    <= 1'b0;
      cnt_reg    <= '0;
      shift_reg  <= '0;
      nbits_reg  <= 4'h0;
      active_reg <= 1'b0;
    end else begin
      env_reg <= env;
      cnt_reg <= (rise | fall) ? '0 : (gap_hit ? cnt_reg : cnt_reg + 1'b1);
      if (fall) begin
        shift_reg  <= shifted;
        nbits_reg  <= (nbits_reg == 4'h8) ? 4'h0 : nbits_reg + 4'h1;
        active_reg <= 1'b1;
      end else if (gap_hit) begin
        nbits_reg  <= 4'h0;
        active_reg <= 1'b0;
      end
    end
  end

  // byte out after the ninth (parity) bit; odd parity over all nine
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      byte_valid <= 1'b0;
      byte_data  <= 8'h00;
      parity_ok  <= 1'b0;
      frame_end  <= 1'b0;
    end else begin
      byte_valid <= fall & (nbits_reg == 4'h8);
      byte_data  <= shifted[8:1];
      parity_ok  <= ^shifted;
      frame_end  <= gap_hit;
    end
  end
endmodule

//--- rtl/if_switch_control.sv
// control logic of the eight-input, four-output if switch matrix
`timescale 1ns/1ps
module if_switch_control #(
  parameter int unsigned CHANNELS    = 4,
  parameter int unsigned CW          = 20,
  parameter int unsigned THRESH_CYC  = if_switch_pkg::BIT_THRESH_CYC,
  parameter int unsigned GAP_CYC     = if_switch_pkg::GAP_CYC,
  parameter int unsigned TX_BIT_CYC  = if_switch_pkg::TX_BIT_CYC,
  parameter int unsigned TX_ONE_CYC  = if_switch_pkg::TX_ONE_CYC,
  parameter int unsigned TX_ZERO_CYC = if_switch_pkg::TX_ZERO_CYC
) (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic [CHANNELS-1:0]   cmd_bus_in,
  input  wire logic [CHANNELS-1:0]   vt_volt_in,
  input  wire logic [CHANNELS-1:0]   vt_tone_in,
  input  wire logic [CHANNELS-1:0]   rx_present_in,
  input  wire logic [1:0]            mode_in,
  input  wire logic [1:0]            gain_in,
  input  wire logic [7:0]            addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic [31:0]                rdata,
  output logic [4*CHANNELS-1:0]      receiver_feed_sel,
  output logic [CHANNELS-1:0]        chained_feed_en,
  output logic [1:0]                 gain_code,
  output logic [1:0]                 mode_code,
  output logic [CHANNELS-1:0]        cmd_return_out
);
  generate
    if (CHANNELS != 4 || TX_ONE_CYC >= TX_ZERO_CYC || TX_ZERO_CYC >= TX_BIT_CYC
        || TX_BIT_CYC >= (64'd1 << CW)) begin : g_bad
      $error("if_switch_control: channel count or reply timing not servable");
    end
  endgenerate

  // ===========================================================
  // pin synchronisers
  localparam int unsigned PW = 4 * CHANNELS + 4;
  logic [PW-1:0] s1_reg;
  logic [PW-1:0] s2_reg;
  logic [PW-1:0] s3_reg;
  logic [PW-1:0] pin_reg;
  wire  [PW-1:0] pin_raw = {cmd_bus_in, vt_volt_in, vt_tone_in, rx_present_in,
                            mode_in, gain_in};

  // a bit only moves once the second and third stage agree
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      pin_reg <= '0;
    end else begin
      s1_reg  <= pin_raw;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg | s3_reg));
    end
  end

  wire [CHANNELS-1:0] env_s     = pin_reg[PW-1 -: CHANNELS];
  wire [CHANNELS-1:0] volt_s    = pin_reg[PW-1-CHANNELS -: CHANNELS];
  wire [CHANNELS-1:0] tone_s    = pin_reg[PW-1-2*CHANNELS -: CHANNELS];
  wire [CHANNELS-1:0] present_s = pin_reg[PW-1-3*CHANNELS -: CHANNELS];
  wire [1:0]          mode_s    = pin_reg[3:2];
  wire [1:0]          gain_s    = pin_reg[1:0];

  // ===========================================================
  // mode and gain
  // levels are static straps; they follow the filtered pins, which do not move in use
  wire master = (mode_code == if_switch_pkg::MODE_MASTER);
  wire lnb    = (mode_code == if_switch_pkg::MODE_LNB);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_code       <= if_switch_pkg::MODE_LNB;
      gain_code       <= if_switch_pkg::GAIN_0DB;
      chained_feed_en <= '0;
    end else begin
      mode_code       <= mode_s;
      gain_code       <= (gain_s == 2'h3) ? if_switch_pkg::GAIN_12DB : gain_s;
      chained_feed_en <= {CHANNELS{mode_s == if_switch_pkg::MODE_MASTER}};
    end
  end

  // ===========================================================
  // register port
  logic [CHANNELS-1:0] ctrl_reg;   // per channel: return output shows envelope
  logic [CHANNELS-1:0] bus_ctl;
  logic [CHANNELS-1:0] asleep;
  logic [4*CHANNELS-1:0] sw_flat;

  wire hit_ctrl   = (addr == if_switch_pkg::REG_CTRL);
  wire hit_status = (addr == if_switch_pkg::REG_STATUS);
  wire hit_select = (addr == if_switch_pkg::REG_SELECT);
  wire hit_switch = (addr == if_switch_pkg::REG_SWITCH);
  wire [31:0] rd_mux =
      hit_ctrl   ? {28'h0, ctrl_reg} :
      hit_status ? {20'h0, asleep, bus_ctl, gain_code, mode_code} :
      hit_select ? {16'h0, receiver_feed_sel} :
      hit_switch ? {16'h0, sw_flat} : 32'h0;  // unmapped reads zero

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= if_switch_pkg::CTRL_RESET;
      rdata    <= 32'h0;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_reg <= wdata[CHANNELS-1:0];
      end
      rdata <= rd ? rd_mux : 32'h0;  // data stand only in the cycle after the strobe
    end
  end

  // ===========================================================
  // per channel decoder
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      logic        byte_valid;
      logic [7:0]  byte_data;
      logic        parity_ok;
      logic        frame_end;

      // each channel listens only to its own command pin
      envelope_slicer #(
        .CW         (CW),
        .THRESH_CYC (THRESH_CYC),
        .GAP_CYC    (GAP_CYC)
      ) u_slicer (
        .clock      (clock),
        .resetn     (resetn),
        .env        (env_s[ch]),
        .byte_valid (byte_valid),
        .byte_data  (byte_data),
        .parity_ok  (parity_ok),
        .frame_end  (frame_end)
      );

      if_switch_pkg::frame_t        frame_reg;
      if_switch_pkg::switch_state_t sw_reg;
      if_switch_pkg::switch_state_t sw_next;
      logic [2:0]  nbytes_reg;
      logic        bad_reg;
      logic        present_reg;
      logic        bus_reg;
      logic        sleep_reg;
      logic [3:0]  sel_reg;

      // ---- frame acceptance
      wire framing_ok = (frame_reg.framing[7:3] == if_switch_pkg::FRAMING_TOP);
      wire common_ok  = (frame_reg.addr == if_switch_pkg::ADDR_ANY)
                      | (frame_reg.addr == if_switch_pkg::ADDR_FAMILY);
      wire lnb_addr   = (frame_reg.addr == if_switch_pkg::ADDR_LNB);
      wire sw_addr    = (frame_reg.addr == if_switch_pkg::ADDR_SWITCH);
      // lnb mode takes lnb traffic, every other mode takes switcher traffic
      wire addr_ok    = common_ok | (lnb ? lnb_addr : sw_addr);
      wire is_awake   = (frame_reg.cmd == if_switch_pkg::CMD_AWAKE);
      wire exec = frame_end & ~bad_reg & (nbytes_reg >= 3'h3) & framing_ok & addr_ok
                & (~sleep_reg | is_awake);
      wire connect = present_s[ch] & ~present_reg;  // a receiver newly attached

      // ---- command effects on the switch state
      wire is_switch = (frame_reg.cmd[7:3] == if_switch_pkg::CMD_SWITCH_TOP);
      wire is_n0     = (frame_reg.cmd == if_switch_pkg::CMD_WRITE_N0)
                     & (nbytes_reg >= 3'h4);
      wire is_reset  = (frame_reg.cmd == if_switch_pkg::CMD_RESET);
      always_comb begin
        sw_next = sw_reg;
        if (is_switch) begin
          case (frame_reg.cmd[1:0])
            2'h0:    sw_next.band   = frame_reg.cmd[2];
            2'h1:    sw_next.pol    = frame_reg.cmd[2];
            2'h2:    sw_next.pos    = frame_reg.cmd[2];
            default: sw_next.option = frame_reg.cmd[2];
          endcase
        end else if (is_n0) begin
          // high nibble says which state bits change, low nibble their values
          sw_next = (sw_reg & ~frame_reg.data[7:4]) | (frame_reg.data[3:0] & frame_reg.data[7:4]);
        end else if (is_reset) begin
          sw_next = '0;
        end
      end

      // ---- source index: bus state or voltage/tone levels
      wire [3:0] vt_idx  = {1'b0, 1'b0, volt_s[ch], tone_s[ch]};
      wire [3:0] bus_idx = {1'b0, sw_reg.pos, sw_reg.pol, sw_reg.band};
      wire [3:0] base    = bus_reg ? bus_idx : vt_idx;
      // option b picks the chained feed, which only exists in master mode
      wire [3:0] sel_next = (bus_reg & sw_reg.option & master)
                          ? if_switch_pkg::SEL_CHAINED : base;

      // ---- frame capture
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          frame_reg  <= '0;
          nbytes_reg <= 3'h0;
          bad_reg    <= 1'b0;
        end else if (frame_end) begin
          nbytes_reg <= 3'h0;
          bad_reg    <= 1'b0;
        end else if (byte_valid) begin
          case (nbytes_reg)
            3'h0:    frame_reg.framing <= byte_data;
            3'h1:    frame_reg.addr    <= byte_data;
            3'h2:    frame_reg.cmd     <= byte_data;
            3'h3:    frame_reg.data    <= byte_data;
            default: frame_reg.data    <= frame_reg.data;  // surplus bytes dropped
          endcase
          nbytes_reg <= (nbytes_reg == 3'h7) ? nbytes_reg : nbytes_reg + 3'h1;
          bad_reg    <= bad_reg | ~parity_ok;
        end
      end

      // ---- control source and switch state
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          present_reg <= 1'b0;
          bus_reg     <= 1'b0;   // voltage/tone after power-up
          sleep_reg   <= 1'b0;
          sw_reg      <= '0;
          sel_reg     <= if_switch_pkg::SEL_RESET;
        end else begin
          present_reg <= present_s[ch];
          // a valid command wins over a connect in the same cycle
          if (exec) begin
            bus_reg <= 1'b1;
          end else if (connect) begin
            bus_reg <= 1'b0;
          end
          if (exec) begin
            sw_reg <= sw_next;
            if (frame_reg.cmd == if_switch_pkg::CMD_SLEEP) begin
              sleep_reg <= 1'b1;
            end else if (is_awake || is_reset) begin
              sleep_reg <= 1'b0;
            end
          end
          sel_reg <= sel_next;
        end
      end

      // ---- reply serializer
      if_switch_pkg::tx_state_t tx_state;
      logic [CW-1:0] tx_cnt;
      logic [8:0]    tx_shift;
      logic [3:0]    tx_left;
      logic          tx_level;
      wire [CW-1:0]  tone_len = tx_shift[8] ? CW'(TX_ONE_CYC) : CW'(TX_ZERO_CYC);
      wire           want_reply = exec & frame_reg.framing[if_switch_pkg::FRAMING_REPLY_BIT];

      // one reply byte with odd parity, each bit a tone then silence
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          tx_state <= if_switch_pkg::TX_IDLE;
          tx_cnt   <= '0;
          tx_shift <= 9'h0;
          tx_left  <= 4'h0;
          tx_level <= 1'b0;
        end else begin
          tx_cnt <= tx_cnt + 1'b1;
          case (tx_state)
            if_switch_pkg::TX_IDLE: begin
              tx_level <= 1'b0;
              if (want_reply) begin
                tx_shift <= {if_switch_pkg::REPLY_BYTE, ~^if_switch_pkg::REPLY_BYTE};
                tx_left  <= 4'h9;
                tx_cnt   <= '0;
                tx_level <= 1'b1;
                tx_state <= if_switch_pkg::TX_TONE;
              end
            end
            if_switch_pkg::TX_TONE: begin
              if (tx_cnt == tone_len - 1'b1) begin
                tx_level <= 1'b0;
                tx_state <= if_switch_pkg::TX_GAP;
              end
            end
            if_switch_pkg::TX_GAP: begin
              if (tx_cnt == CW'(TX_BIT_CYC) - 1'b1) begin
                tx_cnt   <= '0;
                tx_shift <= {tx_shift[7:0], 1'b0};
                tx_left  <= tx_left - 4'h1;
                if (tx_left == 4'h1) begin
                  tx_state <= if_switch_pkg::TX_IDLE;
                end else begin
                  tx_level <= 1'b1;
                  tx_state <= if_switch_pkg::TX_TONE;
                end
              end
            end
            default: begin
              tx_level <= 1'b0;
              tx_state <= if_switch_pkg::TX_IDLE;
            end
          endcase
        end
      end

      // return pin: envelope passthrough or reply, chosen by software
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          cmd_return_out[ch] <= 1'b0;
        end else begin
          cmd_return_out[ch] <= ctrl_reg[ch] ? env_s[ch] : tx_level;
        end
      end

      assign receiver_feed_sel[4*ch +: 4] = sel_reg;
      assign bus_ctl[ch]                  = bus_reg;
      assign asleep[ch]                   = sleep_reg;
      assign sw_flat[4*ch +: 4]           = sw_reg;
    end
  endgenerate
endmodule

//--- dv/if_switch_properties.sv
// concurrent checks on the ports of the switch matrix control
`timescale 1ns/1ps
module if_switch_properties #(
  parameter int unsigned CHANNELS = 4
) (
  input wire logic                  clock,
  input wire logic                  resetn,
  input wire logic [1:0]            mode_in,
  input wire logic [1:0]            gain_in,
  input wire logic                  rd,
  input wire logic [31:0]           rdata,
  input wire logic [4*CHANNELS-1:0] receiver_feed_sel,
  input wire logic [CHANNELS-1:0]   chained_feed_en,
  input wire logic [1:0]            gain_code,
  input wire logic [1:0]            mode_code
);
  // ==========================================================
  // helpers: any select out of range, any ninth source not enabled
  wire logic       sel_over;
  wire logic       ninth_bad;
  wire logic [1:0] gain_exp;
  assign sel_over  = (receiver_feed_sel[3:0] > 4'h8) || (receiver_feed_sel[7:4] > 4'h8) ||
                     (receiver_feed_sel[11:8] > 4'h8) || (receiver_feed_sel[15:12] > 4'h8);
  assign ninth_bad = (receiver_feed_sel[3:0] == 4'h8 && !chained_feed_en[0]) ||
                     (receiver_feed_sel[7:4] == 4'h8 && !chained_feed_en[1]) ||
                     (receiver_feed_sel[11:8] == 4'h8 && !chained_feed_en[2]) ||
                     (receiver_feed_sel[15:12] == 4'h8 && !chained_feed_en[3]);
  assign gain_exp  = (gain_in == 2'h3) ? 2'h2 : gain_in;  // top code folds onto +12
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // mode, gain and select relations
  a_master_feeds_on: assert property (mode_code == if_switch_pkg::MODE_MASTER
    |-> chained_feed_en == '1) else $error("chained feeds off in master mode");
  a_other_feeds_off: assert property (mode_code != if_switch_pkg::MODE_MASTER
    |-> chained_feed_en == '0) else $error("chained feeds on outside master mode");
  a_ninth_gated: assert property (!ninth_bad)
    else $error("ninth source selected while its feed is disabled");
  a_sel_in_range: assert property (!sel_over)
    else $error("select beyond nine sources");
  a_reset_first_feed: assert property (disable iff (1'b0) !resetn
    |-> receiver_feed_sel == '0 && chained_feed_en == '0) else $error("outputs not cleared");
  a_mode_follows: assert property ($stable(mode_in) [*8] |-> mode_code == mode_in)
    else $error("mode code does not follow steady mode input");
  a_gain_common: assert property ($stable(gain_in) [*8] |-> gain_code == gain_exp)
    else $error("gain code does not follow steady gain input");
  a_codes_held: assert property ($stable(mode_in) [*8] ##1 $stable(mode_in)
    |-> $stable(mode_code)) else $error("mode code moved with a steady input");
  a_read_idle_zero: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data outside the read answer cycle");
endmodule

//--- dv/receiver_model.sv
// behavioural receiver: sends command frames as tone envelopes
`timescale 1ns/1ps
module receiver_model (
  input wire logic clock,
  output logic [3:0] env
);
  // no tone between frames
  initial env = 4'h0;
  // one tone burst and the silence after it, changed just after an edge
  task automatic burst(input int ch, input bit one);
    @(posedge clock) env[ch] <= 1'b1;
    repeat (one ? 10 : 24) @(posedge clock);
    env[ch] <= 1'b0;
    repeat (one ? 19 : 5) @(posedge clock);
  endtask
  // three bytes msb first, each with odd parity, then a closing gap
  task automatic send(input int ch, input logic [23:0] f);
    for (int i = 23; i >= 0; i--) begin
      burst(ch, f[i]);
      if (i % 8 == 0) burst(ch, ~^f[i+:8]);
    end
    repeat (150) @(posedge clock);  // gap well past the frame end count
  endtask
endmodule

//--- dv/testbench.sv
// self-checking bench of the switch matrix control
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // stimulus and observed signals
  typedef struct packed {logic [1:0] m; logic [1:0] g; logic [3:0] v; logic [3:0] t;} row_t;
  logic        clock = 1'b0;
  logic        resetn = 1'b1;
  logic [3:0]  env, ret, en;
  logic [3:0]  volt = 4'h0, tone = 4'h0, present = 4'hf;
  logic [1:0]  mode = 2'h0, gain = 2'h0, gcode, mcode;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic        wr = 1'b0, rd = 1'b0;
  logic [15:0] sel;
  int          n_errors = 0, n_compared = 0, ret_cnt = 0;
  row_t        rows [4] = '{'{2'h0, 2'h0, 4'h5, 4'h3}, '{2'h1, 2'h1, 4'ha, 4'hc},
                            '{2'h2, 2'h2, 4'hf, 4'h0}, '{2'h3, 2'h3, 4'h0, 4'hf}};
  logic [7:0]  sw_cmds [4] = '{8'h23, 8'h26, 8'h24, 8'h25};  // option a, pos b, hi, h
  always #4 clock = ~clock;
  // tone cycles on the channel two return line
  always @(posedge clock) ret_cnt <= ret_cnt + ret[2];
  if_switch_control #(.THRESH_CYC(20), .GAP_CYC(100), .TX_BIT_CYC(30), .TX_ONE_CYC(10),
    .TX_ZERO_CYC(20)) i_if_switch_control (.clock(clock), .resetn(resetn),
    .cmd_bus_in(env), .vt_volt_in(volt), .vt_tone_in(tone), .rx_present_in(present),
    .mode_in(mode), .gain_in(gain), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .receiver_feed_sel(sel), .chained_feed_en(en), .gain_code(gcode),
    .mode_code(mcode), .cmd_return_out(ret));
  receiver_model i_receiver_model (.clock(clock), .env(env));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (10) @(posedge clock);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock) {addr, wdata, wr} <= {a, v, 1'b1};
    @(posedge clock) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock) {addr, rd} <= {a, 1'b1};
    @(posedge clock) rd <= 1'b0;
    #1 v = rdata;  // answer stands only in this cycle
  endtask
  task automatic reconnect(input int ch);
    present[ch] <= 1'b0;
    repeat (6) @(posedge clock);
    present[ch] <= 1'b1;
    settle();
  endtask
  // select expected under voltage/tone control
  function automatic logic [15:0] vt_sel(input logic [3:0] v, input logic [3:0] t);
    for (int n = 0; n < 4; n++) vt_sel[4*n +: 4] = {2'b00, v[n], t[n]};
  endfunction
  function automatic int tone_sum(input logic [23:0] f);
    int s = 0;
    for (int i = 23; i >= 0; i--) s += (f[i] ? 10 : 24) + ((i % 8 == 0) ? (^f[i+:8] ? 24 : 10) : 0);
    return s;
  endfunction
  task automatic ret_count(input logic [23:0] f, input int exp);
    int c;
    c = ret_cnt;
    i_receiver_model.send(2, f);
    repeat (300) @(posedge clock);
    chk(ret_cnt - c, exp);
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (80000) @(posedge clock);
    n_errors++;
    results();
  end
  // ==========================================================
  // main sequence
  initial begin
    resetn <= 1'b0;  // reset edge lands before the first clock edge, so no unknown outputs
    repeat (20) @(posedge clock);
    chk(sel, 16'h0);
    resetn <= 1'b1;
    foreach (rows[r]) begin
      {mode, gain, volt, tone} <= rows[r];
      settle();
      chk(mcode, rows[r].m);
      chk(gcode, rows[r].g == 2'h3 ? 2'h2 : rows[r].g);
      chk(en, rows[r].m == if_switch_pkg::MODE_MASTER ? 4'hf : 4'h0);
      chk(sel, vt_sel(rows[r].v, rows[r].t));
      rd_reg(if_switch_pkg::REG_STATUS, d);
      chk(d[3:0], {((rows[r].g == 2'h3) ? 2'h2 : rows[r].g), rows[r].m});
      $display("row %0d done", r);
    end
    // unmapped read, control write and read back
    rd_reg(8'h40, d);
    chk(d, 32'h0);
    wr_reg(if_switch_pkg::REG_CTRL, 32'h4);
    rd_reg(if_switch_pkg::REG_CTRL, d);
    chk(d, 32'h4);
    wr_reg(if_switch_pkg::REG_CTRL, 32'h0);
    $display("register test done");
    // address class obeyed per mode: lnb, then single
    {volt, tone} <= 8'hff;
    for (int k = 0; k < 2; k++) begin
      mode <= k ? if_switch_pkg::MODE_SINGLE : if_switch_pkg::MODE_LNB;
      reconnect(1);
      i_receiver_model.send(1, {8'he0, k ? 8'h11 : 8'h14, 8'h00});
      chk(sel[7:4], 4'h3);
      i_receiver_model.send(1, {8'he0, k ? 8'h14 : 8'h11, 8'h00});
      chk(sel[7:4], 4'h0);
      reconnect(1);
      chk(sel[7:4], 4'h3);
    end
    $display("address class test done");
    // full switch sequence on channel zero only
    foreach (sw_cmds[i]) i_receiver_model.send(0, {16'he014, sw_cmds[i]});
    chk(sel, 16'h3337);
    {volt, tone} <= 8'h00;
    settle();
    chk(sel, 16'h0007);
    mode <= if_switch_pkg::MODE_MASTER;
    settle();
    i_receiver_model.send(0, 24'he01027);
    chk(sel, 16'h0008);
    reconnect(0);
    chk(sel, 16'h0000);
    // a sleeping channel ignores switching until it is woken
    i_receiver_model.send(3, 24'he01030);
    i_receiver_model.send(3, 24'he01026);
    chk(sel[15:12], 4'h0);
    rd_reg(if_switch_pkg::REG_STATUS, d);
    chk(d[11:4], 8'h88);
    i_receiver_model.send(3, 24'he01031);
    i_receiver_model.send(3, 24'he01026);
    chk(sel[15:12], 4'h4);
    $display("switch test done");
    // reply signalling, then the envelope copy
    ret_count(24'he21000, 130);
    wr_reg(if_switch_pkg::REG_CTRL, 32'h4);
    ret_count(24'he01031, tone_sum(24'he01031));
    $display("return test done");
    results();
  end
endmodule
bind if_switch_control if_switch_properties #(.CHANNELS(CHANNELS)) i_if_switch_properties (
  .clock(clock), .resetn(resetn), .mode_in(mode_in), .gain_in(gain_in), .rd(rd),
  .rdata(rdata), .receiver_feed_sel(receiver_feed_sel), .chained_feed_en(chained_feed_en),
  .gain_code(gain_code), .mode_code(mode_code));
